/* File: logic/pcm_pkg.sv */
// pcm_pkg: constants and types of the power and clock manager
// assumes a 32-bit ahb-lite register port, one register per word
package pcm_pkg;
    localparam logic [7:0] PCM_OFF_PCTL = 8'h00;
    localparam logic [7:0] PCM_OFF_PMODE = 8'h04;
    localparam logic [7:0] PCM_OFF_EXT_IRQ_FLAG_REG = 8'h08;
    localparam logic [7:0] PCM_OFF_STAT = 8'h0C;
    localparam logic [7:0] PCM_OFF_WDOG = 8'h10;
    localparam int PCM_B_IDLE = 0;
    localparam int PCM_B_CDLO = 6;
    localparam int PCM_B_CDHI = 7;
    localparam int PCM_B_SWB = 5;
    localparam int PCM_B_XOFF = 3;
    localparam int PCM_B_OSEL = 3;
    localparam int PCM_B_OSTS = 2;
    localparam int PCM_B_XRDY = 4;
    localparam int PCM_B_SBSY = 1;
    localparam int PCM_B_WIE = 0;
    localparam int PCM_B_WRE = 1;
    localparam int PCM_B_WRS = 2;
    localparam int PCM_B_WFL = 3;
    localparam logic [1:0] PCM_DIV_RSVD = 2'h0;
    localparam logic [1:0] PCM_DIV4 = 2'h1;
    localparam logic [1:0] PCM_DIV64 = 2'h2;
    localparam logic [1:0] PCM_DIV1K = 2'h3;
    localparam logic [9:0] PCM_LIM4 = 10'h003;
    localparam logic [9:0] PCM_LIM64 = 10'h03F;
    localparam logic [9:0] PCM_LIM1K = 10'h3FF;
    localparam logic [7:0] PCM_PMODE_RST = 8'h40;
    localparam logic PCM_OSEL_RST = 1'b0;
    localparam logic [1:0] PCM_RSTPIN_CYC = 2'h2;
    localparam logic [1:0] PCM_RST_HOLD = 2'h2;
    localparam logic [9:0] PCM_WD_RST_CLK = 10'h200;
    localparam int PCM_WD_INT_DEF = 131072;
    typedef enum logic [2:0] {
        PCM_ST_RUN = 3'b001,
        PCM_ST_IDLE = 3'b010,
        PCM_ST_RST = 3'b100
    } pcm_state_t;
endpackage

/* File: logic/pcm_power_clock_manager.sv */
// pcm_power_clock_manager: idle, economy divider, oscillator choice
// assumes serial, irq and cpu strobes arrive on clk; pins are async
//
// Behaviour
// - writing the idle bit enters idle right after that write
// - idle stops only the cpu clock; peripherals keep running
// - in idle ale and store enable go high, ports hold
// - an enabled interrupt clears idle and resumes the cpu
// - reset pin high two machine cycles resets; restart waits until the pin is low again
// - reset out of idle never resumes the next instruction
// - watchdog runs in idle; timeout wakes; reset 512 clocks later
// - divider field picks 4, 64 or 1024 clocks; 00 reserved
// - economy slows peripherals too; idle runs them at clock/4
// - a new divider applies after two machine cycles
// - source select picks crystal or rc; status shows it, delayed
// - selecting crystal is ignored until the crystal is ready
// - switchback on serial or irq activity restores divide-by-4
// - rx start edge or tx buffer write triggers switchback
// - switchback ignores serial flags; slow rate may be reselected
// - divider writes ignored during serial traffic with switchback
// - every reset forces divide-by-4
`timescale 1ns/1ps
`default_nettype none
module pcm_power_clock_manager
    import pcm_pkg::*;
#(
    parameter int WD_INTERVAL = PCM_WD_INT_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic reset_pin,
    input wire logic crystal_warm,
    input wire logic serial_rx_pin,
    input wire logic rx_enable,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic sbuf_write,
    input wire logic ext_irq_ack,
    input wire logic irq_pending,
    input wire logic cpu_ale,
    input wire logic cpu_program_store_enable_n,
    output logic cpu_cycle_en,
    output logic periph_cycle_en,
    output logic cpu_reset,
    output logic osc_select,
    output logic crystal_amp_en,
    output logic ale,
    output logic program_store_enable_n,
    output logic port_hold,
    output logic wd_irq,
    output logic idle_active
);
    logic [2:0] rp_s, xw_s, rx_s;
    logic rp_lvl, xw_lvl, rx_lvl, rx_fall;
    logic acc, wr_ph, pc_wr, pm_wr, ex_wr, wd_wr;
    logic [7:0] ph_addr, wdat, rdv;
    pcm_state_t st;
    logic [1:0] hold, rp_cnt;
    logic ext_hit, wd_fire, rst_req, sys_rst;
    logic [9:0] mc_cnt, lim;
    logic mtick;
    logic [1:0] p4_cnt;
    logic p4tick;
    logic [1:0] div_cur, div_pend, div_age;
    logic switchback_enable, amp_off, sb, sw_fire, div_ok;
    logic src_sel, src_cur, xt_rdy;
    logic [1:0] src_age;
    logic [31:0] wd_cnt;
    logic [9:0] wd_rcnt;
    logic wd_ie, wd_re, wd_flag, wd_arm, wd_to, wd_rs;

    // stage 0 feeds stage 1 only; stages 1 and 2 must agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_s <= 3'h0;
            xw_s <= 3'h0;
            rx_s <= 3'h7;
            rp_lvl <= 1'b0;
            xw_lvl <= 1'b0;
            rx_lvl <= 1'b1;
        end else begin
            rp_s <= {rp_s[1:0], reset_pin};
            xw_s <= {xw_s[1:0], crystal_warm};
            rx_s <= {rx_s[1:0], serial_rx_pin};
            if (rp_s[1] == rp_s[2]) rp_lvl <= rp_s[2];
            if (xw_s[1] == xw_s[2]) xw_lvl <= xw_s[2];
            if (rx_s[1] == rx_s[2]) rx_lvl <= rx_s[2];
        end
    end

    assign rx_fall = rx_lvl & (rx_s[1] == rx_s[2]) & ~rx_s[2];

    // bus slave: zero wait states, always okay
    assign acc = hsel & hready & htrans[1];
    assign wdat = hwdata[7:0];
    assign pc_wr = wr_ph & (ph_addr == PCM_OFF_PCTL);
    assign pm_wr = wr_ph & (ph_addr == PCM_OFF_PMODE);
    assign ex_wr = wr_ph & (ph_addr == PCM_OFF_EXT_IRQ_FLAG_REG);
    assign wd_wr = wr_ph & (ph_addr == PCM_OFF_WDOG);

    always_comb begin
        rdv = 8'h00;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                PCM_OFF_PCTL: rdv[PCM_B_IDLE] = (st == PCM_ST_IDLE);
                PCM_OFF_PMODE: begin
                    rdv[PCM_B_CDHI] = div_cur[1];
                    rdv[PCM_B_CDLO] = div_cur[0];
                    rdv[PCM_B_SWB] = switchback_enable;
                    rdv[PCM_B_XOFF] = amp_off;
                end
                PCM_OFF_EXT_IRQ_FLAG_REG: begin
                    rdv[PCM_B_OSEL] = src_sel;
                    rdv[PCM_B_OSTS] = src_cur;
                end
                PCM_OFF_STAT: begin
                    rdv[PCM_B_XRDY] = xt_rdy;
                    rdv[PCM_B_SBSY] = sb;
                end
                PCM_OFF_WDOG: begin
                    rdv[PCM_B_WIE] = wd_ie;
                    rdv[PCM_B_WRE] = wd_re;
                    rdv[PCM_B_WFL] = wd_flag;
                end
                default: rdv = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ph <= 1'b0;
            ph_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_ph <= acc & hwrite & (haddr[31:8] == 24'h000000);
            ph_addr <= haddr[7:0];
            hrdata <= (acc & ~hwrite) ? {24'h000000, rdv} : 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // machine-cycle counter; a written rate changes at its wrap, switchback and reset change it at once
    always_comb begin
        case (div_cur)
            PCM_DIV64: lim = PCM_LIM64;
            PCM_DIV1K: lim = PCM_LIM1K;
            default: lim = PCM_LIM4;
        endcase
    end
    assign mtick = (mc_cnt == lim);
    assign p4tick = (p4_cnt == 2'h3);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_cnt <= 10'h000;
            p4_cnt <= 2'h0;
        end else if (sw_fire | sys_rst) begin
            mc_cnt <= 10'h000;
            p4_cnt <= 2'h0;
        end else begin
            mc_cnt <= mtick ? 10'h000 : mc_cnt + 10'h001;
            p4_cnt <= p4_cnt + 2'h1;
        end
    end

    // reset pin qualified in machine cycles, not raw clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_cnt <= 2'h0;
        end else if (!rp_lvl) begin
            rp_cnt <= 2'h0;
        end else if (mtick && rp_cnt != PCM_RSTPIN_CYC) begin
            rp_cnt <= rp_cnt + 2'h1;
        end
    end
    assign ext_hit = rp_lvl & mtick & (rp_cnt == PCM_RSTPIN_CYC - 2'h1);
    assign rst_req = ext_hit | wd_fire;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sys_rst <= 1'b0;
        else sys_rst <= rst_req;
    end

    // power state; reset always leads through the hold state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= PCM_ST_RST;
            hold <= PCM_RST_HOLD;
        end else begin
            if (rst_req) hold <= PCM_RST_HOLD;
            else if (mtick && hold != 2'h0) hold <= hold - 2'h1;
            case (st)
                PCM_ST_RUN: begin
                    if (rst_req) st <= PCM_ST_RST;
                    else if (pc_wr && wdat[PCM_B_IDLE]) st <= PCM_ST_IDLE;
                end
                PCM_ST_IDLE: begin
                    if (rst_req) st <= PCM_ST_RST;
                    else if (irq_pending || (wd_flag && wd_ie)) st <= PCM_ST_RUN;
                end
                PCM_ST_RST: begin
                    if (hold == 2'h0 && !rp_lvl && !rst_req) st <= PCM_ST_RUN;
                end
                default: st <= PCM_ST_RST;
            endcase
        end
    end

    // switchback sources
    assign sb = tx_busy | rx_busy;
    assign sw_fire = switchback_enable & ((rx_fall & rx_enable) | sbuf_write | ext_irq_ack);
    assign div_ok = !(switchback_enable && sb) && wdat[PCM_B_CDHI:PCM_B_CDLO] != PCM_DIV_RSVD;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switchback_enable <= PCM_PMODE_RST[PCM_B_SWB];
            amp_off <= PCM_PMODE_RST[PCM_B_XOFF];
        end else if (sys_rst) begin
            switchback_enable <= PCM_PMODE_RST[PCM_B_SWB];
            amp_off <= PCM_PMODE_RST[PCM_B_XOFF];
        end else if (pm_wr) begin
            switchback_enable <= wdat[PCM_B_SWB];
            amp_off <= wdat[PCM_B_XOFF];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cur <= PCM_PMODE_RST[PCM_B_CDHI:PCM_B_CDLO];
            div_pend <= PCM_PMODE_RST[PCM_B_CDHI:PCM_B_CDLO];
            div_age <= 2'h0;
        end else if (sys_rst || sw_fire) begin
            div_cur <= PCM_DIV4;
            div_age <= 2'h0;
        end else if (pm_wr && div_ok) begin
            div_pend <= wdat[PCM_B_CDHI:PCM_B_CDLO];
            div_age <= 2'h1;
        end else if (mtick && div_age == 2'h2) begin
            div_cur <= div_pend;
            div_age <= 2'h0;
        end else if (mtick && div_age == 2'h1) begin
            div_age <= 2'h2;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) xt_rdy <= 1'b0;
        else xt_rdy <= xw_lvl & ~amp_off;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_sel <= PCM_OSEL_RST;
            src_cur <= PCM_OSEL_RST;
            src_age <= 2'h0;
        end else if (sys_rst) begin
            src_sel <= PCM_OSEL_RST;
            src_cur <= PCM_OSEL_RST;
            src_age <= 2'h0;
        end else if (ex_wr && !(wdat[PCM_B_OSEL] && !xt_rdy)) begin
            src_sel <= wdat[PCM_B_OSEL];
            src_age <= 2'h1;
        end else if (mtick && src_age == 2'h2) begin
            src_cur <= src_sel;
            src_age <= 2'h0;
        end else if (mtick && src_age == 2'h1) begin
            src_age <= 2'h2;
        end
    end

    // watchdog counts peripheral cycles, so it keeps going in idle
    assign wd_rs = wd_wr & wdat[PCM_B_WRS];
    assign wd_to = periph_cycle_en && wd_cnt == 32'(WD_INTERVAL - 1);
    assign wd_fire = wd_arm & (wd_rcnt == PCM_WD_RST_CLK - 10'h001);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_ie <= 1'b0;
            wd_re <= 1'b0;
        end else if (wd_wr) begin
            wd_ie <= wdat[PCM_B_WIE];
            wd_re <= wdat[PCM_B_WRE];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt <= 32'h00000000;
            wd_flag <= 1'b0;
            wd_arm <= 1'b0;
            wd_rcnt <= 10'h000;
        end else if (sys_rst || wd_rs) begin
            wd_cnt <= 32'h00000000;
            wd_arm <= 1'b0;
            wd_rcnt <= 10'h000;
            if (sys_rst) wd_flag <= 1'b0;
            else if (wd_to) wd_flag <= 1'b1;
            else if (wdat[PCM_B_WFL]) wd_flag <= 1'b0;
        end else begin
            if (periph_cycle_en) wd_cnt <= wd_to ? 32'h00000000 : wd_cnt + 32'h00000001;
            if (wd_to) wd_flag <= 1'b1;
            else if (wd_wr && wdat[PCM_B_WFL]) wd_flag <= 1'b0;
            if (wd_to && wd_re && !wd_arm) begin
                wd_arm <= 1'b1;
                wd_rcnt <= 10'h000;
            end else if (wd_arm) begin
                wd_rcnt <= wd_rcnt + 10'h001;
            end
        end
    end

    // all outputs registered; pin overrides follow the power state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_cycle_en <= 1'b0;
            periph_cycle_en <= 1'b0;
            cpu_reset <= 1'b1;
            osc_select <= PCM_OSEL_RST;
            crystal_amp_en <= 1'b1;
            ale <= 1'b1;
            program_store_enable_n <= 1'b1;
            port_hold <= 1'b0;
            wd_irq <= 1'b0;
            idle_active <= 1'b0;
        end else begin
            cpu_cycle_en <= mtick && st == PCM_ST_RUN && !rst_req;
            periph_cycle_en <= (st == PCM_ST_IDLE) ? p4tick : mtick;
            cpu_reset <= (st == PCM_ST_RST) || rst_req;
            osc_select <= src_cur;
            crystal_amp_en <= ~amp_off;
            ale <= (st == PCM_ST_IDLE) ? 1'b1 : cpu_ale;
            program_store_enable_n <= (st == PCM_ST_IDLE) ? 1'b1
                : cpu_program_store_enable_n;
            port_hold <= (st == PCM_ST_IDLE);
            wd_irq <= wd_flag & wd_ie;
            idle_active <= (st == PCM_ST_IDLE);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    idle_entry_a: assert property (
        st == PCM_ST_RUN && pc_wr && wdat[PCM_B_IDLE] && !rst_req
        |=> st == PCM_ST_IDLE ##1 idle_active && !cpu_cycle_en)
        else $error("idle not entered after idle write");
    cpu_gate_a: assert property (
        st == PCM_ST_IDLE |=> !cpu_cycle_en)
        else $error("cpu cycle enabled in idle");
    pin_hold_a: assert property (
        st == PCM_ST_IDLE |=> ale && program_store_enable_n && port_hold)
        else $error("pins not held in idle");
    irq_wake_a: assert property (
        st == PCM_ST_IDLE && irq_pending && !rst_req |=> st == PCM_ST_RUN)
        else $error("interrupt did not end idle");
    idle_reset_a: assert property (
        st == PCM_ST_IDLE && rst_req |=> st == PCM_ST_RST ##1 cpu_reset)
        else $error("reset out of idle resumed the cpu");
    xtal_gate_a: assert property (
        ex_wr && wdat[PCM_B_OSEL] && !xt_rdy && !sys_rst
        |=> src_sel == $past(src_sel))
        else $error("crystal selected before ready");
    switch_back_a: assert property (
        sw_fire |=> div_cur == PCM_DIV4 && mc_cnt == 10'h000)
        else $error("switchback did not restore divide by four");
    reset_div_a: assert property (
        rst_req |=> sys_rst ##1 div_cur == PCM_DIV4)
        else $error("reset did not force divide by four");

    idle_wake_c: cover property (
        st == PCM_ST_IDLE ##1 st == PCM_ST_RUN);
    switch_back_c: cover property (div_cur == PCM_DIV64 && sw_fire);
    wd_reset_c: cover property (wd_fire);
endmodule
`default_nettype wire

/* File: bench/pcm_far_side.sv */
// pcm_far_side: behavioural cpu core, serial line and irq controller
// assumes the bench asks for start bits and interrupts by one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module pcm_far_side (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic idle_active,
    input wire logic start_frame,
    input wire logic irq_req,
    output logic serial_rx_pin,
    output logic cpu_ale,
    output logic cpu_program_store_enable_n,
    output logic irq_pending
);
    logic [3:0] low_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 4'h0;
        else if (start_frame) low_cnt <= 4'h8;
        else if (low_cnt != 4'h0) low_cnt <= low_cnt - 4'h1;
    end
    // line idles high between frames
    assign serial_rx_pin = (low_cnt == 4'h0);
    // strobes move every clock so a frozen pin shows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_ale <= 1'b0;
            cpu_program_store_enable_n <= 1'b0;
        end else begin
            cpu_ale <= ~cpu_ale;
            cpu_program_store_enable_n <= cpu_ale;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) irq_pending <= 1'b0;
        else if (irq_req) irq_pending <= 1'b1;
        else if (!idle_active) irq_pending <= 1'b0;
    end
endmodule
`default_nettype wire

/* File: bench/power_clock_manager_test.sv */
// power_clock_manager_test: self-checking bench of the clock manager
// assumes one 250 MHz clock, ahb-lite master here, far side in pcm_far_side
`timescale 1ns/1ps
`default_nettype none
module power_clock_manager_test
    import pcm_pkg::*;
;
    logic clk, rst_n, hsel, hwrite, reset_pin, crystal_warm, rx_enable, tx_busy, rx_busy;
    logic sbuf_write, ext_irq_ack, start_frame, irq_req, serial_rx_pin, cpu_ale, irq_pending;
    logic hreadyout, hresp, cpu_cycle_en, periph_cycle_en, cpu_reset, osc_select;
    logic crystal_amp_en, ale, program_store_enable_n, port_hold, wd_irq, idle_active;
    logic cpu_program_store_enable_n;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, sl;
    int miscompares, checked, p, n, first;
    time t0;

    pcm_power_clock_manager #(.WD_INTERVAL(16)) pcm_power_clock_manager_i (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reset_pin(reset_pin),
        .crystal_warm(crystal_warm), .serial_rx_pin(serial_rx_pin), .rx_enable(rx_enable),
        .tx_busy(tx_busy), .rx_busy(rx_busy), .sbuf_write(sbuf_write),
        .ext_irq_ack(ext_irq_ack), .irq_pending(irq_pending), .cpu_ale(cpu_ale),
        .cpu_program_store_enable_n(cpu_program_store_enable_n),
        .cpu_cycle_en(cpu_cycle_en), .periph_cycle_en(periph_cycle_en),
        .cpu_reset(cpu_reset), .osc_select(osc_select), .crystal_amp_en(crystal_amp_en),
        .ale(ale), .program_store_enable_n(program_store_enable_n),
        .port_hold(port_hold), .wd_irq(wd_irq), .idle_active(idle_active));

    pcm_far_side pcm_far_side_i (
        .clk(clk), .rst_n(rst_n), .idle_active(idle_active), .start_frame(start_frame),
        .irq_req(irq_req), .serial_rx_pin(serial_rx_pin), .cpu_ale(cpu_ale),
        .cpu_program_store_enable_n(cpu_program_store_enable_n), .irq_pending(irq_pending));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // address phase held until hready, then data phase
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 100);
        q = hrdata;
    endtask

    task wr(input logic [31:0] a, input logic [7:0] d);
        ahb(1'b1, a, ($urandom() & 32'hFFFFFF00) | {24'h0, d});
    endtask

    task rd(input logic [31:0] a);
        ahb(1'b0, a, $urandom());
    endtask

    function logic pulse(input int s);
        return s != 0 ? periph_cycle_en : cpu_cycle_en;
    endfunction

    function int clocks_of(input logic [1:0] s);
        return s == PCM_DIV64 ? 64 : s == PCM_DIV1K ? 1024 : 4;
    endfunction

    // clocks between two strobes of the chosen enable
    task period(input int s);
        int k;
        k = 0;
        while (pulse(s) !== 1'b1 && k < 3000) begin @(posedge clk); k++; end
        p = 0;
        do begin @(posedge clk); p++; end while (pulse(s) !== 1'b1 && p < 3000);
    endtask

    // skip the transitional periods after a change
    task settle;
        repeat (3) period(0);
    endtask

    task wait_low(input int lim);
        n = 0;
        while (cpu_reset !== 1'b0 && n < lim) begin @(posedge clk); n++; end
    endtask

    initial begin
        {rst_n, hsel, hwrite, reset_pin, crystal_warm, tx_busy, rx_busy} = 7'h0;
        {sbuf_write, ext_irq_ack, start_frame, irq_req} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        rx_enable = 1'b1;
        miscompares = 0;
        checked = 0;
        void'($urandom(32'h39567F17));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(PCM_OFF_PMODE);
        check(q, {24'h0, PCM_PMODE_RST});
        check(32'({hresp, hreadyout}), 32'h1);
        rd(32'h40 | ($urandom() & 32'hFF00));
        check(q, 32'h0);
        wr(PCM_OFF_PMODE, 8'h00);
        rd(PCM_OFF_PMODE);
        check(32'(q[7:6]), 32'(PCM_DIV4));
        first = $urandom_range(0, 1);
        for (int i = 0; i < 2; i++) begin
            sl = ((i ^ first) != 0) ? PCM_DIV1K : PCM_DIV64;
            wr(PCM_OFF_PMODE, {sl, 6'h00});
            settle();
            check(p, clocks_of(sl));
            period(1);
            check(p, clocks_of(sl));
            wr(PCM_OFF_PMODE, 8'h40);
            settle();
            check(p, 4);
        end
        for (int t = 0; t < 3; t++) begin
            wr(PCM_OFF_PMODE, {PCM_DIV64, 6'h20});
            settle();
            check(p, 64);
            case (t)
                0: sbuf_write <= 1'b1;
                1: start_frame <= 1'b1;
                default: ext_irq_ack <= 1'b1;
            endcase
            @(posedge clk);
            {sbuf_write, start_frame, ext_irq_ack} <= 3'h0;
            repeat (20) @(posedge clk);
            settle();
            check(p, 4);
            rd(PCM_OFF_PMODE);
            check(32'(q[7:6]), 32'(PCM_DIV4));
        end
        if ($urandom_range(0, 1) != 0) tx_busy <= 1'b1;
        else rx_busy <= 1'b1;
        wr(PCM_OFF_PMODE, {PCM_DIV64, 6'h20});
        // give an accepted write time to apply, so a leak would show
        repeat (12) @(posedge clk);
        rd(PCM_OFF_PMODE);
        check(32'(q[7:6]), 32'(PCM_DIV4));
        {tx_busy, rx_busy} <= 2'h0;
        wr(PCM_OFF_PMODE, {PCM_DIV64, 6'h00});
        settle();
        wr(PCM_OFF_PCTL, 8'h01);
        repeat (3) @(posedge clk);
        check(32'({idle_active, ale, program_store_enable_n, port_hold}), 32'hF);
        n = 0;
        repeat (160) begin @(posedge clk); if (cpu_cycle_en !== 1'b0) n++; end
        check(n, 0);
        period(1);
        check(p, 4);
        rd(PCM_OFF_PCTL);
        check(q, 32'h1);
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        repeat (4) @(posedge clk);
        check(32'(idle_active), 32'h0);
        rd(PCM_OFF_PCTL);
        check(q, 32'h0);
        wr(PCM_OFF_PCTL, 8'h01);
        repeat (3) @(posedge clk);
        // pin held past two machine cycles
        reset_pin <= 1'b1;
        repeat (170) @(posedge clk);
        check(32'({cpu_reset, idle_active}), 32'h2);
        reset_pin <= 1'b0;
        wait_low(100);
        check(32'(n <= 16), 32'h1);
        rd(PCM_OFF_PCTL);
        check(q, 32'h0);
        rd(PCM_OFF_PMODE);
        check(32'(q[7:6]), 32'(PCM_DIV4));
        wr(PCM_OFF_EXT_IRQ_FLAG_REG, 8'h08);
        repeat (12) @(posedge clk);
        check(32'(osc_select), 32'h0);
        wr(PCM_OFF_PMODE, 8'h48);
        repeat (2) @(posedge clk);
        check(32'(crystal_amp_en), 32'h0);
        crystal_warm <= 1'b1;
        repeat (6) @(posedge clk);
        rd(PCM_OFF_STAT);
        check(32'(q[4]), 32'h0);
        wr(PCM_OFF_PMODE, 8'h40);
        repeat (6) @(posedge clk);
        rd(PCM_OFF_STAT);
        check(32'(q[4]), 32'h1);
        wr(PCM_OFF_EXT_IRQ_FLAG_REG, 8'h08);
        check(32'(osc_select), 32'h0);
        repeat (12) @(posedge clk);
        check(32'(osc_select), 32'h1);
        rd(PCM_OFF_EXT_IRQ_FLAG_REG);
        check(32'(q[3:2]), 32'h3);
        // clear the flag left by earlier timeouts so the wake is real
        wr(PCM_OFF_WDOG, 8'h0F);
        wr(PCM_OFF_PCTL, 8'h01);
        n = 0;
        while (wd_irq !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        repeat (3) @(posedge clk);
        check(32'(idle_active), 32'h0);
        wr(PCM_OFF_WDOG, 8'h0F);
        n = 0;
        repeat (540) begin @(posedge clk); if (cpu_reset !== 1'b0) n++; end
        check(n, 0);
        wr(PCM_OFF_WDOG, 8'h0F);
        // wd_irq is registered: let the cleared flag reach it
        repeat (2) @(posedge clk);
        n = 0;
        while (wd_irq !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        // slow rate before the watchdog reset, which must undo it
        t0 = $time;
        wr(PCM_OFF_PMODE, 8'h80);
        n = int'(($time - t0) / 4);
        while (cpu_reset !== 1'b1 && n < 700) begin @(posedge clk); n++; end
        check(32'(n >= 500 && n <= 530), 32'h1);
        wait_low(200);
        wr(PCM_OFF_WDOG, 8'h08);
        rd(PCM_OFF_PMODE);
        check(32'(q[7:6]), 32'(PCM_DIV4));
        stop_test();
    end

    initial begin
        #300000;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
